// >>> inc/usbc_pkg.sv
// Constants, types and helpers shared by the USB function-core controller
// Summary of operation
// - Writing state 010 plus the received address enters the addressed state.
// - Address and addressed state are written only after set-address status stage completes.
// - Writing state 100 after configuration requests enters the configured state.
// - Endpoint enable order: max packet size, then transfer mode, then endpoint-reset command.
// - Setup token sets setup flag; clear it by writing 1 after reading flags.
// - Short data is closed with the short-packet end command on endpoint 0.
// - Status packet before setup-finish is NAKed, flagged; setup-finish must then follow.
// - Status-NAK mask stays 1; set 0 only for data-stage requests before setup-received.
// - On status-NAK: clear flag, issue setup-finish, then set the mask back to 1.
// - Commands carry endpoint and code fields; 0x4 stalls, 0x5 invalidates the endpoint.
package usbc_pkg;
  // Core register map
  localparam logic [7:0] DEV_ADR_OFS = 8'h00;
  localparam logic [7:0] DEV_INT_OFS = 8'h04;
  localparam logic [7:0] DEV_CMD_OFS = 8'h08;
  localparam logic [7:0] DEV_SETUP0_OFS = 8'h14;
  localparam logic [7:0] DEV_SETUP1_OFS = 8'h18;
  localparam logic [7:0] DEV_EPMSZ_BASE = 8'h20;
  localparam logic [7:0] DEV_EPSTS_BASE = 8'h24;
  localparam logic [7:0] DEV_EP_STRIDE = 8'h08;
  // Address/state register fields
  localparam int ADR_STATE_LSB = 8;
  localparam logic [2:0] ADR_STATE_DEFAULT = 3'h1;
  localparam logic [2:0] ADR_STATE_ADDRESSED = 3'h2;
  localparam logic [2:0] ADR_STATE_CONFIGURED = 3'h4;
  // Interrupt flag register bits
  localparam int INT_SETUP_BIT = 0;
  localparam int INT_STATUS_NAK_BIT = 1;
  localparam int INT_STATUS_BIT = 2;
  localparam int EP_ZERO_EVENT_BIT = 3;
  localparam int INT_MASK_NAK_BIT = 17;
  localparam logic MASK_NAK_RESET = 1'b1;
  // Command register fields and codes
  localparam int CMD_EP_LSB = 4;
  localparam logic [3:0] CMD_SETUP_RECEIVED = 4'h1;
  localparam logic [3:0] CMD_SETUP_FIN = 4'h2;
  localparam logic [3:0] CMD_ENDPOINT_RESET_CMD = 4'h3;
  localparam logic [3:0] CMD_ENDPOINT_STALL_CMD = 4'h4;
  localparam logic [3:0] CMD_ENDPOINT_INVALID_CMD = 4'h5;
  localparam logic [3:0] CMD_USB_READY = 4'h6;
  localparam logic [3:0] CMD_EOP = 4'h7;
  // Software-facing register map
  localparam logic [7:0] SW_CTRL_OFS = 8'h00;
  localparam logic [7:0] SW_ADDR_OFS = 8'h04;
  localparam logic [7:0] SW_EPCFG_OFS = 8'h08;
  localparam logic [7:0] SW_PASS_ADDR_OFS = 8'h0C;
  localparam logic [7:0] SW_PASS_DATA_OFS = 8'h10;
  localparam logic [7:0] SW_STATUS_OFS = 8'h14;
  localparam logic [7:0] SW_SETUP0_OFS = 8'h18;
  localparam logic [7:0] SW_SETUP1_OFS = 8'h1C;
  localparam logic [7:0] SW_PASS_RES_OFS = 8'h20;
  // Order bits of the control register and the arm bit of the address register
  localparam int ORD_BUS_READY = 0;
  localparam int ORD_SETUP_FIN = 1;
  localparam int ORD_EOP = 2;
  localparam int ORD_CONFIG = 3;
  localparam int ORD_EP_ENABLE = 4;
  localparam int ORD_EP_CMD = 5;
  localparam int ORD_PASS = 6;
  localparam int ORD_PASS_WRITE = 7;
  localparam int ORD_W = 7;
  localparam int ADDR_ARM_BIT = 8;
  // Endpoint configuration fields
  localparam int EPCFG_CODE_LSB = 4;
  localparam int EPCFG_MODE_LSB = 8;
  localparam int EPCFG_MSZ_LSB = 16;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_RD_INT = 4'h1, S_CLR_INT = 4'h2, S_RD_SETUP = 4'h3,
    S_MASK_NAK = 4'h4, S_SETUP_RCV = 4'h5, S_NAK_FIN = 4'h6, S_NAK_UNMASK = 4'h7,
    S_EP_MSZ = 4'h8, S_EP_MODE = 4'h9, S_EP_RST = 4'hA, S_OP = 4'hB
  } ctl_state_t;

  // Command word: endpoint number above the code
  function automatic logic [31:0] cmd_word(input logic [3:0] ep, input logic [3:0] code);
    cmd_word = '0;
    cmd_word[CMD_EP_LSB +: 4] = ep;
    cmd_word[3:0] = code;
  endfunction : cmd_word

  // Address/state register word
  function automatic logic [31:0] adr_word(input logic [2:0] state, input logic [6:0] adr);
    adr_word = '0;
    adr_word[ADR_STATE_LSB +: 3] = state;
    adr_word[6:0] = adr;
  endfunction : adr_word
endpackage : usbc_pkg

// >>> inc/dev_bus_if.sv
// Single-access request channel from the sequencer to the core-register master
`timescale 1ns/1ns
interface dev_bus_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  modport ctrl (output req, we, addr, wdata, input done, rdata);
  modport phy (input req, we, addr, wdata, output done, rdata);
endinterface : dev_bus_if

// >>> src/pin_sync.sv
// Three-stage synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ns
module pin_sync (
  input wire logic i_clk_sys, // System clock
  input wire logic i_nrst, // Async reset, active low
  input wire logic i_pin, // Raw pin level
  output logic o_level // Filtered level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_t;
  sync_t cur;
  sync_t next_cur;

  // Level follows only once stages two and three agree; stage one feeds stage two alone
  always_comb begin
    next_cur = cur;
    next_cur.s1 = i_pin;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
    if (cur.s2 == cur.s3) begin
      next_cur.level = cur.s3;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_level = cur.level;
endmodule : pin_sync

// >>> src/dev_reg_master.sv
// Drives one core-register access per request onto the core's register pins
`timescale 1ns/1ns
module dev_reg_master (
  input wire logic i_clk_sys, // System clock
  input wire logic i_nrst, // Async reset, active low
  dev_bus_if.phy bus, // Request channel
  output logic [7:0] o_dev_addr, // Core register address
  output logic [31:0] o_dev_wdata, // Core write data
  output logic o_dev_wr, // Core write strobe
  output logic o_dev_rd, // Core read strobe
  input wire logic [31:0] i_dev_rdata // Core read data, cycle after strobe
);
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic done;
  } mst_t;
  mst_t cur;
  mst_t next_cur;

  // Strobes are one cycle; done marks the cycle the core read data is valid
  always_comb begin
    next_cur = cur;
    next_cur.wr = bus.req && bus.we;
    next_cur.rd = bus.req && !bus.we;
    next_cur.done = cur.wr || cur.rd;
    if (bus.req) begin
      next_cur.addr = bus.addr;
      next_cur.wdata = bus.we ? bus.wdata : '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_dev_addr = cur.addr;
  assign o_dev_wdata = cur.wdata;
  assign o_dev_wr = cur.wr;
  assign o_dev_rd = cur.rd;
  assign bus.done = cur.done;
  assign bus.rdata = i_dev_rdata;

  a_read_slot: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    cur.rd |=> (cur.done && !cur.rd && !cur.wr)) else $error("read answer slot missed");
endmodule : dev_reg_master

// >>> src/usb_core_ctl.sv
// Controller that enumerates and services endpoint 0 of the USB function core
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
module usb_core_ctl
  import usbc_pkg::*;
(
  input wire logic i_clk_sys, // System clock, 20 MHz
  input wire logic i_nrst, // Async reset, active low
  input wire logic [7:0] i_addr, // Software register address
  input wire logic [31:0] i_wdata, // Software write data
  input wire logic i_wr, // Software write strobe
  input wire logic i_rd, // Software read strobe
  output logic [31:0] o_rdata, // Read data, cycle after strobe
  output logic [7:0] o_dev_addr, // Core register address
  output logic [31:0] o_dev_wdata, // Core write data
  output logic o_dev_wr, // Core write strobe
  output logic o_dev_rd, // Core read strobe
  input wire logic [31:0] i_dev_rdata, // Core read data
  input wire logic i_dev_irq // Core combined interrupt pin
);
  typedef struct packed {
    ctl_state_t st;
    logic issued;
    logic req;
    logic we;
    logic [7:0] daddr;
    logic [31:0] dwdata;
    logic [7:0] op_addr;
    logic op_we;
    logic [31:0] op_data;
    logic [3:0] flags;
    logic pend_nak;
    logic pend_stat;
    logic [ORD_W-1:0] orders;
    logic pass_we;
    logic [6:0] addr_pend;
    logic addr_arm;
    logic [6:0] cur_addr;
    logic [31:0] ep_cfg;
    logic [7:0] pass_addr;
    logic [31:0] pass_data;
    logic [31:0] pass_res;
    logic [31:0] setup0;
    logic [31:0] setup1;
    logic setup_idx;
    logic has_data;
    logic mask_nak;
    logic [1:0] dev_state;
    logic [31:0] rdata;
  } ctl_t;

  ctl_t cur;
  ctl_t next_cur;
  logic irq_level;
  logic [ORD_W-1:0] set_ord;
  logic [ORD_W-1:0] clr_ord;
  logic set_arm;
  logic clr_arm;
  logic step;
  logic [7:0] oa;
  logic ow;
  logic [31:0] od;
  logic [3:0] ep_sel;

  dev_bus_if dbus ();

  pin_sync u_irq_sync (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_pin(i_dev_irq),
    .o_level(irq_level)
  );

  dev_reg_master u_master (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .bus(dbus.phy),
    .o_dev_addr(o_dev_addr),
    .o_dev_wdata(o_dev_wdata),
    .o_dev_wr(o_dev_wr),
    .o_dev_rd(o_dev_rd),
    .i_dev_rdata(i_dev_rdata)
  );

  assign ep_sel = cur.ep_cfg[3:0];

  // Core access that the current state performs
  always_comb begin
    oa = DEV_INT_OFS;
    ow = 1'b0;
    od = '0;
    unique case (cur.st)
      S_IDLE, S_RD_INT: begin
        oa = DEV_INT_OFS;
      end
      S_CLR_INT: begin
        ow = 1'b1; // Write ones where flags were seen; bit 17 carries the held mask
        od = {14'h0000, cur.mask_nak, 13'h0000, cur.flags};
      end
      S_RD_SETUP: begin
        oa = cur.setup_idx ? DEV_SETUP1_OFS : DEV_SETUP0_OFS;
      end
      S_MASK_NAK: begin
        ow = 1'b1; // Unmask status-NAK for a data-stage request
        od = '0;
      end
      S_SETUP_RCV: begin
        oa = DEV_CMD_OFS;
        ow = 1'b1;
        od = cmd_word(4'h0, CMD_SETUP_RECEIVED);
      end
      S_NAK_FIN: begin
        oa = DEV_CMD_OFS;
        ow = 1'b1; // Status packet was NAKed, so finish now
        od = cmd_word(4'h0, CMD_SETUP_FIN);
      end
      S_NAK_UNMASK: begin
        ow = 1'b1; // Re-arm the mask for the next transfer
        od = '0;
        od[INT_MASK_NAK_BIT] = MASK_NAK_RESET;
      end
      S_EP_MSZ: begin
        oa = 8'(DEV_EPMSZ_BASE + DEV_EP_STRIDE * {4'h0, ep_sel});
        ow = 1'b1; // Max packet size goes first
        od = {21'h000000, cur.ep_cfg[EPCFG_MSZ_LSB +: 11]};
      end
      S_EP_MODE: begin
        oa = 8'(DEV_EPSTS_BASE + DEV_EP_STRIDE * {4'h0, ep_sel});
        ow = 1'b1; // Transfer mode second
        od = {24'h000000, cur.ep_cfg[EPCFG_MODE_LSB +: 8]};
      end
      S_EP_RST: begin
        oa = DEV_CMD_OFS;
        ow = 1'b1; // Endpoint reset last
        od = cmd_word(ep_sel, CMD_ENDPOINT_RESET_CMD);
      end
      S_OP: begin
        oa = cur.op_addr;
        ow = cur.op_we;
        od = cur.op_data;
      end
      default: begin
        oa = DEV_INT_OFS;
      end
    endcase
  end

  // Sequencer, software port and order bookkeeping
  always_comb begin
    next_cur = cur;
    next_cur.req = 1'b0;
    next_cur.rdata = '0;
    set_ord = '0;
    clr_ord = '0;
    set_arm = 1'b0;
    clr_arm = 1'b0;
    step = 1'b0;
    // Software writes; orders are sticky until served
    if (i_wr) begin
      unique case (i_addr)
        SW_CTRL_OFS: begin
          set_ord = i_wdata[ORD_W-1:0];
          if (i_wdata[ORD_PASS]) begin
            next_cur.pass_we = i_wdata[ORD_PASS_WRITE];
          end
        end
        SW_ADDR_OFS: begin
          next_cur.addr_pend = i_wdata[6:0];
          set_arm = i_wdata[ADDR_ARM_BIT];
        end
        SW_EPCFG_OFS: next_cur.ep_cfg = i_wdata;
        SW_PASS_ADDR_OFS: next_cur.pass_addr = i_wdata[7:0];
        SW_PASS_DATA_OFS: next_cur.pass_data = i_wdata;
        default: ;
      endcase
    end
    // Software reads; unmapped addresses read zero
    if (i_rd) begin
      unique case (i_addr)
        SW_CTRL_OFS: next_cur.rdata = {24'h000000, cur.pass_we, cur.orders};
        SW_ADDR_OFS: next_cur.rdata = {23'h000000, cur.addr_arm, 1'b0, cur.addr_pend};
        SW_EPCFG_OFS: next_cur.rdata = cur.ep_cfg;
        SW_PASS_ADDR_OFS: next_cur.rdata = {24'h000000, cur.pass_addr};
        SW_PASS_DATA_OFS: next_cur.rdata = cur.pass_data;
        SW_STATUS_OFS: next_cur.rdata = {11'h000, cur.mask_nak, cur.flags, cur.has_data, cur.addr_arm,
                                         cur.dev_state, cur.cur_addr, cur.st != S_IDLE, cur.st};
        SW_SETUP0_OFS: next_cur.rdata = cur.setup0;
        SW_SETUP1_OFS: next_cur.rdata = cur.setup1;
        SW_PASS_RES_OFS: next_cur.rdata = cur.pass_res;
        default: next_cur.rdata = '0;
      endcase
    end
    // One core access in flight; done ends the state
    if (cur.st != S_IDLE) begin
      if (!cur.issued) begin
        next_cur.req = 1'b1;
        next_cur.issued = 1'b1;
        next_cur.daddr = oa;
        next_cur.we = ow;
        next_cur.dwdata = od;
      end else if (dbus.done) begin
        next_cur.issued = 1'b0;
        step = 1'b1;
      end
    end
    unique case (cur.st)
      S_IDLE: begin
        if (cur.pend_nak) begin
          next_cur.pend_nak = 1'b0;
          next_cur.st = S_NAK_FIN;
        end else if (cur.pend_stat && cur.addr_arm) begin
          // Address only after the set-address status stage has ended
          next_cur.pend_stat = 1'b0;
          clr_arm = 1'b1;
          next_cur.cur_addr = cur.addr_pend;
          next_cur.op_addr = DEV_ADR_OFS;
          next_cur.op_we = 1'b1;
          next_cur.op_data = adr_word(ADR_STATE_ADDRESSED, cur.addr_pend);
          next_cur.dev_state = 2'h2;
          next_cur.st = S_OP;
        end else if (irq_level) begin
          next_cur.st = S_RD_INT;
        end else if (cur.orders != '0) begin
          next_cur.pend_stat = 1'b0; // A stale completion has nothing to release
          next_cur.op_addr = DEV_CMD_OFS;
          next_cur.op_we = 1'b1;
          next_cur.st = S_OP;
          if (cur.orders[ORD_BUS_READY]) begin
            clr_ord[ORD_BUS_READY] = 1'b1;
            next_cur.op_data = cmd_word(4'h0, CMD_USB_READY);
            next_cur.dev_state = 2'h1;
          end else if (cur.orders[ORD_SETUP_FIN]) begin
            clr_ord[ORD_SETUP_FIN] = 1'b1;
            next_cur.op_data = cmd_word(4'h0, CMD_SETUP_FIN);
          end else if (cur.orders[ORD_EOP]) begin
            clr_ord[ORD_EOP] = 1'b1;
            next_cur.op_data = cmd_word(4'h0, CMD_EOP); // Short packet is always on endpoint 0
          end else if (cur.orders[ORD_CONFIG]) begin
            clr_ord[ORD_CONFIG] = 1'b1;
            next_cur.op_addr = DEV_ADR_OFS;
            next_cur.op_data = adr_word(ADR_STATE_CONFIGURED, cur.cur_addr);
            next_cur.dev_state = 2'h3;
          end else if (cur.orders[ORD_EP_ENABLE]) begin
            clr_ord[ORD_EP_ENABLE] = 1'b1;
            next_cur.st = S_EP_MSZ;
          end else if (cur.orders[ORD_EP_CMD]) begin
            clr_ord[ORD_EP_CMD] = 1'b1;
            next_cur.op_data = cmd_word(ep_sel, cur.ep_cfg[EPCFG_CODE_LSB +: 4]);
          end else begin
            clr_ord[ORD_PASS] = 1'b1;
            next_cur.op_addr = cur.pass_addr;
            next_cur.op_we = cur.pass_we;
            next_cur.op_data = cur.pass_data;
          end
        end
      end
      S_RD_INT: begin
        if (step) begin
          // The synchronised irq lags a clear, so a reread can see no flags; writing back zero would drop the mask
          next_cur.flags = (dbus.rdata[3:0] != 4'h0) ? dbus.rdata[3:0] : cur.flags;
          next_cur.pend_stat = cur.pend_stat | dbus.rdata[INT_STATUS_BIT];
          next_cur.st = (dbus.rdata[3:0] != 4'h0) ? S_CLR_INT : S_IDLE;
        end
      end
      S_CLR_INT: begin
        if (step) begin
          // A setup token outranks a pending status NAK, which waits in IDLE
          if (cur.flags[INT_STATUS_NAK_BIT] && !cur.mask_nak) begin
            next_cur.pend_nak = cur.flags[INT_SETUP_BIT];
          end
          if (cur.flags[INT_SETUP_BIT]) begin
            next_cur.setup_idx = 1'b0;
            next_cur.st = S_RD_SETUP;
          end else if (cur.flags[INT_STATUS_NAK_BIT] && !cur.mask_nak) begin
            next_cur.st = S_NAK_FIN;
          end else begin
            next_cur.st = S_IDLE;
          end
        end
      end
      S_RD_SETUP: begin
        if (step) begin
          if (!cur.setup_idx) begin
            next_cur.setup0 = dbus.rdata;
            next_cur.setup_idx = 1'b1;
          end else begin
            next_cur.setup1 = dbus.rdata;
            next_cur.has_data = dbus.rdata[31:16] != 16'h0000;
            next_cur.st = (dbus.rdata[31:16] != 16'h0000) ? S_MASK_NAK : S_SETUP_RCV;
          end
        end
      end
      S_MASK_NAK: begin
        if (step) begin
          next_cur.mask_nak = 1'b0;
          next_cur.st = S_SETUP_RCV;
        end
      end
      S_NAK_FIN: begin
        if (step) begin
          next_cur.st = S_NAK_UNMASK;
        end
      end
      S_NAK_UNMASK: begin
        if (step) begin
          next_cur.mask_nak = MASK_NAK_RESET;
          next_cur.st = S_IDLE;
        end
      end
      S_EP_MSZ: if (step) next_cur.st = S_EP_MODE;
      S_EP_MODE: if (step) next_cur.st = S_EP_RST;
      S_OP: begin
        if (step) begin
          if (!cur.op_we) begin
            next_cur.pass_res = dbus.rdata;
          end
          next_cur.st = S_IDLE;
        end
      end
      S_SETUP_RCV, S_EP_RST: if (step) next_cur.st = S_IDLE;
      default: next_cur.st = S_IDLE;
    endcase
    // Software setting an order or arm wins over the clear in the same cycle
    next_cur.orders = (cur.orders & ~clr_ord) | set_ord;
    next_cur.addr_arm = (cur.addr_arm & ~clr_arm) | set_arm;
  end

  // State register; mask shadow starts at its documented default
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cur <= '0;
      cur.mask_nak <= MASK_NAK_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign dbus.req = cur.req;
  assign dbus.we = cur.we;
  assign dbus.addr = cur.daddr;
  assign dbus.wdata = cur.dwdata;
  assign o_rdata = cur.rdata;

  sequence s_wr(logic [7:0] a);
    cur.req && cur.we && cur.daddr == a;
  endsequence
  sequence s_cmd(logic [3:0] c);
    s_wr(DEV_CMD_OFS) ##0 cur.dwdata[3:0] == c;
  endsequence

  a_addr_pattern: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_wr(DEV_ADR_OFS) |-> (cur.dwdata[ADR_STATE_LSB +: 3] == ADR_STATE_ADDRESSED
      || cur.dwdata[ADR_STATE_LSB +: 3] == ADR_STATE_CONFIGURED)) else $error("bad state pattern");
  a_addr_after_status: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_wr(DEV_ADR_OFS) ##0 cur.dwdata[ADR_STATE_LSB +: 3] == ADR_STATE_ADDRESSED
    |-> $past(cur.pend_stat, 2) && $past(cur.addr_arm, 2)) else $error("address before status end");
  a_config_keeps_addr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_wr(DEV_ADR_OFS) ##0 cur.dwdata[ADR_STATE_LSB +: 3] == ADR_STATE_CONFIGURED
    |-> cur.dwdata[6:0] == cur.cur_addr && cur.dev_state == 2'h3) else $error("configure lost address");
  a_ep_enable_order: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_wr(DEV_EPMSZ_BASE + DEV_EP_STRIDE * {4'h0, ep_sel}) |-> ##4 s_wr(DEV_EPSTS_BASE
      + DEV_EP_STRIDE * {4'h0, ep_sel}) ##4 s_cmd(CMD_ENDPOINT_RESET_CMD)) else $error("endpoint enable order");
  a_setup_flag_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_wr(DEV_INT_OFS) ##0 cur.dwdata[INT_SETUP_BIT]
    |-> $past(cur.req && !cur.we && cur.daddr == DEV_INT_OFS, 4)) else $error("flag cleared unread");
  a_eop_on_ep0: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_cmd(CMD_EOP) |-> cur.dwdata[CMD_EP_LSB +: 4] == 4'h0) else $error("short packet end off ep0");
  a_nak_chain: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_wr(DEV_INT_OFS) ##0 (cur.dwdata[INT_STATUS_NAK_BIT] && !cur.dwdata[INT_SETUP_BIT] && !cur.mask_nak)
    |-> ##4 s_cmd(CMD_SETUP_FIN) ##4 (s_wr(DEV_INT_OFS) ##0 cur.dwdata[INT_MASK_NAK_BIT]))
    else $error("status nak not served");
  a_mask_before_rcv: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_wr(DEV_INT_OFS) ##0 cur.dwdata == 32'h00000000 |-> ##4 s_cmd(CMD_SETUP_RECEIVED))
    else $error("mask not followed by setup received");
  a_cmd_target: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_cmd(CMD_ENDPOINT_STALL_CMD) or s_cmd(CMD_ENDPOINT_INVALID_CMD) |-> cur.dwdata[CMD_EP_LSB +: 4] == ep_sel)
    else $error("command on wrong endpoint");
  a_one_access: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    cur.req |=> !cur.req [*3]) else $error("overlapping core accesses");
endmodule : usb_core_ctl

// >>> bench/core_model.sv
// Behavioural model of the USB function core register block
`timescale 1ns/1ns
module core_model #(
  parameter logic [31:0] SU0 = 32'h0, // Setup word one
  parameter logic [31:0] SU1 = 32'h0 // Setup word two
) (
  input wire logic i_clk_sys, // Clock
  input wire logic i_nrst, // Reset, active low
  input wire logic [7:0] i_addr, // Register address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [3:0] i_set, // Bus events raising flags
  input wire logic [15:0] i_len, // Length field of the pending request
  output logic [31:0] o_rdata, // Read data
  output logic o_irq, // Combined flag level
  output logic [31:0] o_adr, // Address and state register
  output logic [31:0] o_cmd // Last command word
);
  logic [3:0] flags;
  logic mask;
  logic clr;
  assign o_irq = |flags;
  assign clr = i_wr && (i_addr == 8'h04);
  // Bus events win over a clear landing in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      flags <= 4'h0;
      mask <= 1'b1;
      o_adr <= 32'h0;
      o_cmd <= 32'h0;
      o_rdata <= 32'h0;
    end else begin
      flags <= (flags & ~(clr ? i_wdata[3:0] : 4'h0)) | i_set;
      if (clr) mask <= i_wdata[17];
      if (i_wr && i_addr == 8'h00) o_adr <= i_wdata;
      if (i_wr && i_addr == 8'h08) o_cmd <= i_wdata;
      // Stale read data is inverted so a late sample cannot match by luck
      if (i_rd) begin
        case (i_addr)
          8'h00: o_rdata <= o_adr;
          8'h04: o_rdata <= {14'h0, mask, 13'h0, flags};
          8'h14: o_rdata <= SU0;
          8'h18: o_rdata <= {i_len, SU1[15:0]};
          default: o_rdata <= 32'h0;
        endcase
      end else o_rdata <= ~o_rdata;
    end
  end
endmodule : core_model

// >>> bench/usb_core_ctl_tb.sv
// Self-checking bench for the endpoint-0 controller
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module usb_core_ctl_tb;
  import usbc_pkg::*;
  logic i_clk_sys, i_nrst, i_wr, i_rd, irq, dev_wr, dev_rd;
  logic [7:0] i_addr, dev_addr;
  logic [31:0] i_wdata, o_rdata, dev_wdata, dev_rdata, adr, cmd, rv;
  logic [3:0] ev;
  logic [15:0] wlen;
  int miscompares = 0;
  int n_tests = 0;
  usb_core_ctl u_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_dev_addr(dev_addr), .o_dev_wdata(dev_wdata), .o_dev_wr(dev_wr),
    .o_dev_rd(dev_rd), .i_dev_rdata(dev_rdata), .i_dev_irq(irq));
  // Set-address request with no data stage
  core_model #(.SU0(32'h00050500), .SU1(32'h0)) u_core (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_addr(dev_addr), .i_wdata(dev_wdata), .i_wr(dev_wr), .i_rd(dev_rd), .i_set(ev), .o_rdata(dev_rdata),
    .o_irq(irq), .o_adr(adr), .o_cmd(cmd), .i_len(wlen));
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd
  // Bus event pulses one cycle, as the core would flag it
  task automatic raise(input logic [3:0] f);
    @(posedge i_clk_sys);
    ev <= f;
    @(posedge i_clk_sys);
    ev <= 4'h0;
  endtask : raise
  // Bounded wait for the command word or the address register to settle
  task automatic expect_dev(input bit sel, input logic [31:0] exp);
    int k;
    k = 0;
    while ((sel ? adr : cmd) !== exp && k < 80) begin
      @(posedge i_clk_sys);
      k++;
    end
    `CHK(sel ? adr : cmd, exp)
  endtask : expect_dev
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (4000) @(posedge i_clk_sys);
    miscompares++;
    close_out();
  end
  initial begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    ev = 4'h0;
    wlen = 16'h0;
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    rd(SW_STATUS_OFS);
    `CHK(rv[13:12], 2'h0)
    `CHK(adr, 32'h0)
    $display("test reset done");
    wr(SW_CTRL_OFS, 32'h1);
    expect_dev(1'b0, 32'h6);
    $display("test connect done");
    wr(SW_ADDR_OFS, 32'h105);
    raise(4'h1); // Setup token once the host has reset the bus
    expect_dev(1'b0, 32'h1);
    `CHK(irq, 1'b0)
    wr(SW_CTRL_OFS, 32'h2);
    expect_dev(1'b0, 32'h2);
    raise(4'h4);
    expect_dev(1'b1, 32'h205);
    $display("test set address done");
    wr(SW_CTRL_OFS, 32'h8);
    expect_dev(1'b1, 32'h405);
    $display("test configure done");
    // Endpoint 1 readied with packet size 64 and mode 2, then a short packet closed on endpoint 0
    wr(SW_EPCFG_OFS, 32'h00400201);
    wr(SW_CTRL_OFS, 32'h10);
    expect_dev(1'b0, 32'h13);
    wr(SW_CTRL_OFS, 32'h4);
    expect_dev(1'b0, 32'h7);
    $display("test endpoint enable done");
    for (int c = 4; c < 6; c++) begin
      wr(SW_EPCFG_OFS, 32'h2 | 32'(c << 4));
      wr(SW_CTRL_OFS, 32'h20);
      expect_dev(1'b0, 32'h20 | 32'(c));
    end
    $display("test commands done");
    // Request with a data stage: mask off before setup received, then a status NAK is served
    wlen <= 16'h0012;
    raise(4'h1);
    expect_dev(1'b0, 32'h1);
    rd(SW_STATUS_OFS);
    `CHK({rv[20], rv[15]}, 2'h1)
    raise(4'h8);
    repeat (20) @(posedge i_clk_sys);
    `CHK(irq, 1'b0)
    raise(4'h2);
    expect_dev(1'b0, 32'h2);
    repeat (8) @(posedge i_clk_sys);
    rd(SW_STATUS_OFS);
    `CHK(rv[20], 1'b1)
    $display("test data stage done");
    // Pass-through read of the first setup word
    wr(SW_PASS_ADDR_OFS, 32'h14);
    wr(SW_CTRL_OFS, 32'h40);
    repeat (10) @(posedge i_clk_sys);
    rd(SW_PASS_RES_OFS);
    `CHK(rv, 32'h00050500)
    rd(8'hFC);
    `CHK(rv, 32'h0)
    $display("test pass-through done");
    close_out();
  end
endmodule : usb_core_ctl_tb
